// ### hdl/dpr_pkg.sv
package dpr_pkg;

  // data path geometry of the large ram ports
  localparam int DPR_DATA_W = 72;
  localparam int DPR_ADDR_W = 16;
  localparam int DPR_LANES = 8;
  localparam int DPR_LANE_W = 9;
  localparam int DPR_SLICE_W = 12;
  localparam int DPR_MEM_AW = 13;

  // single-port split: 16 words of 72 bits stay within 2k bits
  localparam int DPR_SP_BITS = 2048;
  localparam int DPR_SP_AW = 4;

  // register offsets (byte addresses)
  localparam logic [7:0] DPR_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPR_STAT_OFS = 8'h04;

  // control field positions and reset value
  localparam int DPR_CTRL_MODE_LSB = 0;
  localparam int DPR_CTRL_BYP_A_BIT = 2;
  localparam int DPR_CTRL_BYP_B_BIT = 3;
  localparam logic [31:0] DPR_CTRL_RST = 32'h0000_0000;

  // status field positions
  localparam int DPR_STAT_WR_LSB = 0;
  localparam int DPR_STAT_RD_LSB = 16;

  // byte lanes default high so a write hangs on the strobe alone
  localparam logic [7:0] DPR_BE_RST = 8'hff;

  typedef enum logic [1:0] {
    DPR_MODE_INDEP = 2'b00,
    DPR_MODE_IO = 2'b01,
    DPR_MODE_RW = 2'b10,
    DPR_MODE_SP = 2'b11
  } dpr_mode_t;

  // clocks, enables and clears of one port (shared control interface)
  typedef struct packed {
    logic clk;
    logic oclk;
    logic ce_in;
    logic ce_out;
    logic clr_in;
    logic clr_out;
  } dpr_ctl_t;

  // input register group of one port
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] be;
    logic we;
    logic [71:0] din;
  } dpr_req_t;

  localparam dpr_req_t DPR_REQ_RST = '{addr: 16'h0000, be: DPR_BE_RST, we: 1'b0, din: 72'h0};

endpackage : dpr_pkg

// ### hdl/dpr_port.sv
`timescale 1ns/1ps
module dpr_port
  import dpr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dpr_mode_t mode,
  input wire logic bypass,
  input wire dpr_ctl_t ctl,
  input wire dpr_req_t req,
  input wire logic rden,
  input wire logic [71:0] q,
  output dpr_req_t cap,
  output logic cap_rden,
  output logic go,
  output logic [71:0] dout
);

  logic clk_q;
  logic oclk_q;

  // port clock edges, sampled on the system clock
  wire in_edge = ctl.clk & ~clk_q;
  wire io_mode = (mode == DPR_MODE_IO);
  wire out_edge = io_mode ? (ctl.oclk & ~oclk_q) : in_edge;
  // split enables and clears only in input/output clock mode
  wire out_ce = io_mode ? ctl.ce_out : ctl.ce_in;
  wire out_clr = io_mode ? ctl.clr_out : ctl.clr_in;
  wire in_rst_n = presetn & ~ctl.clr_in;
  wire out_rst_n = presetn & ~out_clr;

  // edge detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      oclk_q <= 1'b0;
    end else begin
      clk_q <= ctl.clk;
      oclk_q <= ctl.oclk;
    end
  end

  always_ff @(posedge pclk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      cap <= DPR_REQ_RST;
      go <= 1'b0;
    end else begin
      go <= in_edge & ctl.ce_in;
      if (in_edge && ctl.ce_in) begin
        cap <= req;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_rden <= 1'b0;
    end else if (in_edge && ctl.ce_in) begin
      cap_rden <= rden;
    end
  end

  always_ff @(posedge pclk or negedge out_rst_n) begin
    if (!out_rst_n) begin
      dout <= 72'h0;
    end else if (bypass) begin
      dout <= q;
    end else if (out_edge && out_ce) begin
      dout <= q;
    end
  end

endmodule : dpr_port

// ### hdl/dpr_ram.sv
`timescale 1ns/1ps
module dpr_ram
  import dpr_pkg::*;
#(
  parameter int MEM_AW = DPR_MEM_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // each port's clocks, enables and clears on its own control bus
  input wire dpr_ctl_t ctl_a,
  input wire dpr_ctl_t ctl_b,
  input wire dpr_req_t req_a,
  input wire dpr_req_t req_b,
  input wire logic rden_b,
  // 72-bit read data per port, six 12-bit slices
  output logic [71:0] dout_a,
  output logic [71:0] dout_b
);

  logic [31:0] ctrl_reg;
  logic [15:0] wr_cnt_reg;
  logic [15:0] rd_cnt_reg;
  logic [71:0] q_a_reg;
  logic [71:0] q_b_reg;
  logic [71:0] mem [2**MEM_AW];
  dpr_req_t cap_a;
  dpr_req_t cap_b;
  logic go_a;
  logic go_b;
  logic rden_a_q;
  logic rden_b_q;

  // register address decode: 0 none, 1 control, 2 status
  function automatic logic [1:0] dpr_dec(input logic [31:0] a);
    if (a[31:8] != 24'h0) begin
      dpr_dec = 2'd0;
    end else if (a[7:0] == DPR_CTRL_OFS) begin
      dpr_dec = 2'd1;
    end else if (a[7:0] == DPR_STAT_OFS) begin
      dpr_dec = 2'd2;
    end else begin
      dpr_dec = 2'd0;
    end
  endfunction : dpr_dec

  // memory word index; single-port mode pins each port to its own small region
  function automatic logic [MEM_AW-1:0] dpr_idx(input logic [15:0] a, input logic hi,
                                                input logic sp);
    logic [MEM_AW-1:0] r;
    r = a[MEM_AW-1:0];
    if (sp) begin
      r = '0;
      r[DPR_SP_AW-1:0] = a[DPR_SP_AW-1:0];
      r[MEM_AW-1] = hi;
    end
    dpr_idx = r;
  endfunction : dpr_idx

  // configuration fields
  wire dpr_mode_t mode = dpr_mode_t'(ctrl_reg[DPR_CTRL_MODE_LSB +: 2]);
  wire byp_a = ctrl_reg[DPR_CTRL_BYP_A_BIT];
  wire byp_b = ctrl_reg[DPR_CTRL_BYP_B_BIT];
  wire rw_mode = (mode == DPR_MODE_RW);
  wire sp_mode = (mode == DPR_MODE_SP);

  // apb decode
  wire [1:0] hit = dpr_dec(paddr);
  wire acc = psel & penable;
  wire wr_fire = acc & pready & pwrite;
  wire [31:0] stat_val = {rd_cnt_reg, wr_cnt_reg};
  wire [31:0] rd_val = (hit == 2'd1) ? ctrl_reg : ((hit == 2'd2) ? stat_val : 32'h0);

  // port a on its own clock
  dpr_port u_port_a (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode),
    .bypass(byp_a),
    .ctl(ctl_a),
    .req(req_a),
    .rden(1'b0),
    .q(q_a_reg),
    .cap(cap_a),
    .cap_rden(rden_a_q),
    .go(go_a),
    .dout(dout_a)
  );

  // port b on its own clock
  dpr_port u_port_b (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode),
    .bypass(byp_b),
    .ctl(ctl_b),
    .req(req_b),
    .rden(rden_b),
    .q(q_b_reg),
    .cap(cap_b),
    .cap_rden(rden_b_q),
    .go(go_b),
    .dout(dout_b)
  );

  wire wr_a = go_a & cap_a.we;
  wire rd_a = go_a & ~cap_a.we & ~rw_mode;
  wire wr_b = go_b & cap_b.we & ~rw_mode;
  wire rd_b = go_b & (rw_mode ? rden_b_q : ~cap_b.we);
  wire [MEM_AW-1:0] idx_a = dpr_idx(cap_a.addr, 1'b0, sp_mode);
  wire [MEM_AW-1:0] idx_b = dpr_idx(cap_b.addr, 1'b1, sp_mode);

  // write gated by strobe and lanes
  // any lane pattern, 9 bits each
  always_ff @(posedge pclk) begin
    for (int i = 0; i < DPR_LANES; i++) begin
      if (wr_a && cap_a.be[i]) begin
        mem[idx_a][i*DPR_LANE_W +: DPR_LANE_W] <= cap_a.din[i*DPR_LANE_W +: DPR_LANE_W];
      end
      if (wr_b && cap_b.be[i]) begin
        mem[idx_b][i*DPR_LANE_W +: DPR_LANE_W] <= cap_b.din[i*DPR_LANE_W +: DPR_LANE_W];
      end
    end
  end

  // raw read data of each port, old contents on a clash
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_a_reg <= 72'h0;
      q_b_reg <= 72'h0;
    end else begin
      if (rd_a) begin
        q_a_reg <= mem[idx_a];
      end
      if (rd_b) begin
        q_b_reg <= mem[idx_b];
      end
    end
  end

  // operation counters shown in status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt_reg <= 16'h0000;
      rd_cnt_reg <= 16'h0000;
    end else begin
      wr_cnt_reg <= wr_cnt_reg + 16'(wr_a) + 16'(wr_b);
      rd_cnt_reg <= rd_cnt_reg + 16'(rd_a) + 16'(rd_b);
    end
  end

  // apb slave: one wait state, data and error registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc && !pready) begin
        prdata <= pwrite ? 32'h0 : rd_val;
        pslverr <= (hit == 2'd0);
      end
    end
  end

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= DPR_CTRL_RST;
    end else if (wr_fire && hit == 2'd1) begin
      ctrl_reg <= {28'h0, pwdata[3:0]};
    end
  end

endmodule : dpr_ram

// ### dv/dpr_ram_props.sv
`timescale 1ns/1ps
module dpr_props
  import dpr_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input dpr_ctl_t ctl_a,
  input dpr_ctl_t ctl_b,
  input logic [71:0] dout_a,
  input logic [71:0] dout_b
);
  // all checks on pclk, idle in reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answer: one wait state, one-cycle pulse
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready late");
  apb_pulse_a: assert property (pready |=> !pready) else $error("ready long");
  apb_err_a: assert property (pready |-> pslverr != (paddr == 32'h0 || paddr == 32'h4))
    else $error("error flag");
  apb_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error data");
  // both clears together empty the read data
  clr_out_a: assert property (ctl_a.clr_in && ctl_a.clr_out |=> dout_a == 72'h0)
    else $error("a not cleared");
  clr_outb_a: assert property (ctl_b.clr_in && ctl_b.clr_out |=> dout_b == 72'h0)
    else $error("b not cleared");
  // read data moves only after its own port clocks; a clear may empty it any time
  hold_a_a: assert property (
    (!ctl_a.clk && !ctl_a.oclk && !ctl_a.clr_in && !ctl_a.clr_out)[*4]
    ##1 (!ctl_a.clr_in && !ctl_a.clr_out) |-> $stable(dout_a)) else $error("a moved");
  hold_b_a: assert property (
    (!ctl_b.clk && !ctl_b.oclk && !ctl_b.clr_in && !ctl_b.clr_out)[*4]
    ##1 (!ctl_b.clr_in && !ctl_b.clr_out) |-> $stable(dout_b)) else $error("b moved");
endmodule : dpr_props

bind dpr_ram dpr_props u_props (.*);

// ### dv/dpr_user.sv
`timescale 1ns/1ps
module dpr_user
  import dpr_pkg::*;
(
  input wire logic pclk,
  output dpr_ctl_t ctl,
  output dpr_req_t req,
  output logic rden
);
  // idle: enables on, clears off, clocks still
  initial begin
    ctl = '{clk: 1'b0, oclk: 1'b0, ce_in: 1'b1, ce_out: 1'b1, clr_in: 1'b0, clr_out: 1'b0};
    req = DPR_REQ_RST;
    rden = 1'b0;
  end
  task automatic op(input logic [15:0] a, input logic [7:0] be, input logic we,
    input logic [71:0] d, input logic ce);
    @(posedge pclk);
    req <= '{addr: a, be: be, we: we, din: d};
    rden <= ~we;
    ctl.ce_in <= ce;
    @(posedge pclk);
    ctl.clk <= 1'b1;
    ctl.oclk <= 1'b1;
    repeat (2) @(posedge pclk);
    ctl.clk <= 1'b0;
    ctl.oclk <= 1'b0;
    @(posedge pclk);
    // released lines carry garbage, not the old value
    req <= ~req;
    rden <= we;
    @(posedge pclk);
  endtask : op
  task automatic clr(input logic ci, input logic co);
    @(posedge pclk);
    ctl.clr_in <= ci;
    ctl.clr_out <= co;
    @(posedge pclk);
    ctl.clr_in <= 1'b0;
    ctl.clr_out <= 1'b0;
    @(posedge pclk);
  endtask : clr
endmodule : dpr_user

// ### dv/dpr_ram_tb.sv
`timescale 1ns/1ps
module dpr_ram_tb;
  import dpr_pkg::*;
  localparam logic [71:0] D1 = 72'h12_3456_789a_bcde_f012;
  localparam logic [71:0] D2 = 72'hfe_dcba_9876_5432_10fe;
  localparam logic [71:0] DM = 72'h12_3456_7896_5432_10fe;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, rden_b;
  dpr_ctl_t ctl_a, ctl_b;
  dpr_req_t req_a, req_b;
  logic [71:0] dout_a, dout_b;
  int errors = 0;
  int n_compared = 0;
  int nw = 0;
  int nr = 0;
  always #5 pclk = ~pclk;
  dpr_ram u_dut (.*);
  dpr_user u_pa (.pclk(pclk), .ctl(ctl_a), .req(req_a), .rden());
  dpr_user u_pb (.pclk(pclk), .ctl(ctl_b), .req(req_b), .rden(rden_b));
  // verdict and end of run
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [71:0] x, input logic [71:0] g);
    n_compared++;
    if (g !== x) begin
      $display("unexpected %s expected %h seen %h", n, x, g);
      errors++;
    end
  endtask : chk
  // one bus transfer, held until the ready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 16) begin
      errors++;
      stop_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // f = {port b, write, enable}; counts what status should show
  task automatic op(input logic [2:0] f, input logic [15:0] a, input logic [7:0] be,
    input logic [71:0] d);
    if (f[2]) u_pb.op(a, be, f[1], d, f[0]);
    else u_pa.op(a, be, f[1], d, f[0]);
    nw += int'(f[1] && f[0]);
    nr += int'(!f[1] && f[0]);
  endtask : op
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 32'(DPR_CTRL_OFS), 32'h0);
    chk("ctrl", 72'(DPR_CTRL_RST), 72'(r));
    apb(1'b1, 32'h40, 32'h5);
    chk("bad write", 72'h1, 72'(e));
    apb(1'b0, 32'h40, 32'h0);
    chk("bad read", 72'h1_0000_0000, 72'({e, r}));
    $display("register test done");
    apb(1'b1, 32'(DPR_CTRL_OFS), 32'hc);
    op(3'h3, 16'h5, 8'hff, D1);
    op(3'h5, 16'h5, 8'hff, 72'h0);
    chk("b read", D1, dout_b);
    op(3'h3, 16'h5, 8'h0f, D2);
    op(3'h2, 16'h5, 8'hff, 72'h0);
    op(3'h5, 16'h5, 8'hff, 72'h0);
    chk("lanes", DM, dout_b);
    op(3'h1, 16'h5, 8'hff, 72'h0);
    chk("a read", DM, dout_a);
    u_pa.clr(1'b1, 1'b1);
    chk("clear", 72'h0, dout_a);
    u_pb.clr(1'b1, 1'b1);
    chk("clear b", 72'h0, dout_b);
    $display("independent test done");
    for (int m = 1; m < 3; m++) begin
      apb(1'b1, 32'(DPR_CTRL_OFS), 32'hc | m);
      op(3'h3, 16'h7, 8'hff, D1 ^ 72'(m));
      op(3'h5, 16'h7, 8'hff, 72'h0);
      chk("mode read", D1 ^ 72'(m), dout_b);
      if (m == 1) begin
        // input/output clock mode: each register group has its own clear
        u_pb.clr(1'b0, 1'b1);
        chk("out clear", 72'h0, dout_b);
        u_pb.clr(1'b1, 1'b0);
        chk("in clear", D1 ^ 72'h1, dout_b);
      end
    end
    apb(1'b1, 32'(DPR_CTRL_OFS), 32'hf);
    op(3'h3, 16'h3, 8'hff, D1);
    op(3'h7, 16'h3, 8'hff, D2);
    op(3'h1, 16'h3, 8'hff, 72'h0);
    op(3'h5, 16'h3, 8'hff, 72'h0);
    chk("single a", D1, dout_a);
    chk("single b", D2, dout_b);
    apb(1'b1, 32'(DPR_CTRL_OFS), 32'h0);
    op(3'h5, 16'h5, 8'hff, 72'h0);
    chk("reg first", D2, dout_b);
    op(3'h5, 16'h5, 8'hff, 72'h0);
    chk("reg second", DM, dout_b);
    apb(1'b0, 32'(DPR_STAT_OFS), 32'h0);
    chk("status", 72'({nr[15:0], nw[15:0]}), 72'(r));
    $display("mode test done");
    stop_test;
  end
endmodule : dpr_ram_tb
